// ===== rtl/quad_timer_pkg.sv
// constants, types and helpers shared by the quad timer block
// assumes a single clock domain, bus pins sampled synchronously to it
package quad_timer_pkg;

    // ==================================================================
    // sizes
    localparam int unsigned NUM_TIMERS = 4;
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned ADDR_W     = 5;
    localparam int unsigned PRESC_W    = 8;

    // ==================================================================
    // register indices on the register select lines
    localparam logic [4:0] ADDR_A_CTRL  = 5'h1A;
    localparam logic [4:0] ADDR_B_CTRL  = 5'h1B;
    localparam logic [4:0] ADDR_CD_CTRL = 5'h1D;
    localparam logic [4:0] ADDR_A_DATA  = 5'h10;
    localparam logic [4:0] ADDR_B_DATA  = 5'h11;
    localparam logic [4:0] ADDR_C_DATA  = 5'h12;
    localparam logic [4:0] ADDR_D_DATA  = 5'h13;

    // ==================================================================
    // field layout
    localparam int unsigned AB_MODE_LSB  = 0;
    localparam int unsigned AB_MODE_W    = 4;
    localparam int unsigned AB_FORCE_BIT = 4;
    localparam int unsigned AB_CTRL_W    = 5;
    localparam int unsigned CD_C_LSB     = 4;
    localparam int unsigned CD_D_LSB     = 0;
    localparam int unsigned CD_MODE_W    = 3;

    // ==================================================================
    // reset values and codes
    localparam logic [4:0] AB_CTRL_RESET = 5'h00;
    localparam logic [2:0] CD_MODE_RESET = 3'h0;
    localparam logic [7:0] CAPTURE_RESET = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    localparam logic [3:0] AB_MODE_STOP  = 4'h0;
    localparam logic [3:0] AB_MODE_EVENT = 4'h8;
    localparam logic [2:0] CD_MODE_STOP  = 3'h0;
    localparam logic [7:0] COUNT_ONE     = 8'h01;
    localparam logic [7:0] PRESC_STEP    = 8'h01;

    // ==================================================================
    // types
    typedef struct packed {
        logic       stopped;
        logic       event_mode;
        logic       pulse_mode;
        logic [7:0] div;
        logic       force_low;
    } chan_ctrl_s;

    typedef enum logic [1:0] {
        BUS_IDLE    = 2'b00,
        BUS_ACK     = 2'b01,
        BUS_RECOVER = 2'b10
    } bus_state_e;

    // prescale select code to divisor
    function automatic logic [7:0] presc_div(input logic [2:0] sel);
        logic [7:0] d;
        d = 8'h01;
        unique case (sel)
            3'h1: d = 8'h04;
            3'h2: d = 8'h0A;
            3'h3: d = 8'h10;
            3'h4: d = 8'h32;
            3'h5: d = 8'h40;
            3'h6: d = 8'h64;
            3'h7: d = 8'hC8;
            3'h0: d = 8'h01;
        endcase
        return d;
    endfunction

endpackage

// ===== rtl/timer_channel.sv
// one timer: prescaler, main down counter, holding register, output toggle
// assumes ctrl is already decoded and aux_level is synchronous, active high
module timer_channel
    import quad_timer_pkg::*;
#(
    parameter int unsigned COUNT_W = 8
) (
    input  wire logic               clk,
    input  wire logic               nrst,
    input  wire chan_ctrl_s         ctrl,
    input  wire logic               aux_level,
    input  wire logic               write_load,
    input  wire logic [COUNT_W-1:0] write_value,
    output logic      [COUNT_W-1:0] count,
    output logic                    timeout,
    output logic                    timer_out
);

    if (COUNT_W != DATA_W) begin : g_width_check
        $error("timer_channel: COUNT_W must equal the bus data width");
    end

    typedef struct packed {
        logic [PRESC_W-1:0] presc;
        logic [COUNT_W-1:0] count;
        logic [COUNT_W-1:0] holding;
        logic               aux_prev;
        logic               out;
        logic               timeout;
    } chan_state_s;

    chan_state_s st;
    chan_state_s next_st;
    logic        tick;

    // ==================================================================
    // next state
    always_comb begin
        next_st = st;
        tick = 1'b0;
        next_st.timeout = 1'b0;
        next_st.aux_prev = aux_level;
        if (ctrl.stopped) begin
            next_st.presc = '0;
        end else if (ctrl.event_mode) begin
            next_st.presc = '0;
            tick = aux_level & ~st.aux_prev;
        end else if (ctrl.pulse_mode && !aux_level) begin
            next_st.presc = st.presc;
        end else if (st.presc >= PRESC_W'(ctrl.div - PRESC_STEP)) begin
            next_st.presc = '0;
            tick = 1'b1;
        end else begin
            next_st.presc = PRESC_W'(st.presc + PRESC_STEP);
        end
        if (tick) begin
            if (st.count == COUNT_W'(COUNT_ONE)) begin
                // a write landing on the reload takes effect at once
                next_st.count = write_load ? write_value : st.holding;
                next_st.timeout = 1'b1;
                next_st.out = ~st.out;
            end else begin
                // zero wraps to all ones: a full 256-pulse period
                next_st.count = COUNT_W'(st.count - 1'b1);
            end
        end
        if (write_load) begin
            next_st.holding = write_value;
            if (ctrl.stopped) begin
                next_st.count = write_value;
            end
        end
        if (ctrl.force_low) begin
            next_st.out = 1'b0;
        end
    end

    // ==================================================================
    // state register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign count = st.count;
    assign timeout = st.timeout;
    assign timer_out = st.out;

endmodule

// ===== rtl/quad_timer_register_control.sv
// four 8-bit down-counting timers behind an asynchronous strobe bus
// assumes bus pins and aux inputs are already synchronous to clk
module quad_timer_register_control
    import quad_timer_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              chip_select_n,
    input  wire logic              bus_data_strobe_n,
    input  wire logic              bus_read_write,
    input  wire logic [ADDR_W-1:0] register_select,
    input  wire logic [DATA_W-1:0] bus_data_in,
    output logic      [DATA_W-1:0] bus_data_out,
    output logic                   bus_data_oe,
    output logic                   dtack_n,
    input  wire logic              first_timer_aux_input,
    input  wire logic              second_timer_aux_input,
    output logic                   first_timer_output,
    output logic                   second_timer_output,
    output logic                   third_timer_output,
    output logic                   fourth_timer_output,
    output logic [NUM_TIMERS-1:0]  timer_timeout
);

    // ==================================================================
    // block state
    typedef struct packed {
        bus_state_e                          bus;
        logic [AB_CTRL_W-1:0]                ctrl_a;
        logic [AB_CTRL_W-1:0]                ctrl_b;
        logic [CD_MODE_W-1:0]                mode_c;
        logic [CD_MODE_W-1:0]                mode_d;
        logic [NUM_TIMERS-1:0][DATA_W-1:0]   capture;
        logic                                strobe_prev;
        logic [DATA_W-1:0]                   rdata;
        logic                                oe;
        logic                                ack;
    } top_state_s;

    top_state_s st;
    top_state_s next_st;

    logic                              selected;
    logic                              take;
    logic                              take_write;
    logic                              strobe_rise;
    logic [NUM_TIMERS-1:0]             data_write;
    logic [NUM_TIMERS-1:0][DATA_W-1:0] counts;
    logic [NUM_TIMERS-1:0]             outs;
    logic [NUM_TIMERS-1:0]             timeouts;
    logic [NUM_TIMERS-1:0]             aux_levels;
    chan_ctrl_s [NUM_TIMERS-1:0]       chan_ctrl;
    logic [DATA_W-1:0]                 read_mux;

    // ==================================================================
    // bus qualification
    assign selected = !chip_select_n && !bus_data_strobe_n;
    assign take = selected && (st.bus == BUS_IDLE);
    assign take_write = take && !bus_read_write;
    assign strobe_rise = !st.strobe_prev && bus_data_strobe_n;

    // data register write strobes go straight to the channels
    always_comb begin
        data_write = '0;
        if (take_write) begin
            unique case (register_select)
                ADDR_A_DATA: data_write[0] = 1'b1;
                ADDR_B_DATA: data_write[1] = 1'b1;
                ADDR_C_DATA: data_write[2] = 1'b1;
                ADDR_D_DATA: data_write[3] = 1'b1;
                default:     data_write = '0;
            endcase
        end
    end

    // ==================================================================
    // mode decode
    function automatic chan_ctrl_s decode_ab(input logic [AB_CTRL_W-1:0] c);
        chan_ctrl_s r;
        logic [AB_MODE_W-1:0] m;
        m = c[AB_MODE_LSB +: AB_MODE_W];
        r.stopped = (m == AB_MODE_STOP);
        r.event_mode = (m == AB_MODE_EVENT);
        r.pulse_mode = m[AB_MODE_W-1] && (m != AB_MODE_EVENT);
        r.div = presc_div(m[AB_MODE_W-2:0]);
        r.force_low = c[AB_FORCE_BIT];
        return r;
    endfunction

    function automatic chan_ctrl_s decode_cd(input logic [CD_MODE_W-1:0] m);
        chan_ctrl_s r;
        r.stopped = (m == CD_MODE_STOP);
        r.event_mode = 1'b0;
        r.pulse_mode = 1'b0;
        r.div = presc_div(m);
        r.force_low = 1'b0;
        return r;
    endfunction

    always_comb begin
        chan_ctrl[0] = decode_ab(st.ctrl_a);
        chan_ctrl[1] = decode_ab(st.ctrl_b);
        chan_ctrl[2] = decode_cd(st.mode_c);
        chan_ctrl[3] = decode_cd(st.mode_d);
    end

    // timers c and d have no aux input; tie their gate inactive
    assign aux_levels = {2'b00, second_timer_aux_input, first_timer_aux_input};

    // ==================================================================
    // read multiplexer
    always_comb begin
        read_mux = READ_UNMAPPED;
        unique case (register_select)
            ADDR_A_CTRL:  read_mux = DATA_W'(st.ctrl_a);
            ADDR_B_CTRL:  read_mux = DATA_W'(st.ctrl_b);
            ADDR_CD_CTRL: read_mux = {1'b0, st.mode_c, 1'b0, st.mode_d};
            ADDR_A_DATA:  read_mux = st.capture[0];
            ADDR_B_DATA:  read_mux = st.capture[1];
            ADDR_C_DATA:  read_mux = st.capture[2];
            ADDR_D_DATA:  read_mux = st.capture[3];
            default:      read_mux = READ_UNMAPPED;
        endcase
    end

    // ==================================================================
    // next state
    always_comb begin
        next_st = st;
        next_st.strobe_prev = bus_data_strobe_n;
        // counter values are frozen for reading on every strobe release
        if (strobe_rise) begin
            next_st.capture = counts;
        end
        unique case (st.bus)
            BUS_IDLE: begin
                if (take) begin
                    next_st.bus = BUS_ACK;
                    next_st.ack = 1'b1;
                    if (bus_read_write) begin
                        next_st.rdata = read_mux;
                        next_st.oe = 1'b1;
                    end else begin
                        unique case (register_select)
                            ADDR_A_CTRL: begin
                                next_st.ctrl_a = bus_data_in[AB_CTRL_W-1:0];
                            end
                            ADDR_B_CTRL: begin
                                next_st.ctrl_b = bus_data_in[AB_CTRL_W-1:0];
                            end
                            ADDR_CD_CTRL: begin
                                next_st.mode_c = bus_data_in[CD_C_LSB +: CD_MODE_W];
                                next_st.mode_d = bus_data_in[CD_D_LSB +: CD_MODE_W];
                            end
                            default: begin
                                next_st.ctrl_a = st.ctrl_a;
                            end
                        endcase
                    end
                end
            end
            BUS_ACK: begin
                // acknowledge stands until the host lets go of the strobe or the chip select
                if (!selected) begin
                    next_st.bus = BUS_RECOVER;
                    next_st.ack = 1'b0;
                    next_st.oe = 1'b0;
                end
            end
            BUS_RECOVER: begin
                next_st.bus = BUS_IDLE;
            end
            default: begin
                next_st.bus = BUS_IDLE;
                next_st.ack = 1'b0;
                next_st.oe = 1'b0;
            end
        endcase
    end

    // ==================================================================
    // state register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st.bus <= BUS_IDLE;
            st.ctrl_a <= AB_CTRL_RESET;
            st.ctrl_b <= AB_CTRL_RESET;
            st.mode_c <= CD_MODE_RESET;
            st.mode_d <= CD_MODE_RESET;
            st.capture <= {NUM_TIMERS{CAPTURE_RESET}};
            st.strobe_prev <= 1'b1;
            st.rdata <= READ_UNMAPPED;
            st.oe <= 1'b0;
            st.ack <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ==================================================================
    // timers
    for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_timer
        timer_channel #(
            .COUNT_W (DATA_W)
        ) u_channel (
            .clk         (clk),
            .nrst        (nrst),
            .ctrl        (chan_ctrl[i]),
            .aux_level   (aux_levels[i]),
            .write_load  (data_write[i]),
            .write_value (bus_data_in),
            .count       (counts[i]),
            .timeout     (timeouts[i]),
            .timer_out   (outs[i])
        );
    end

    // ==================================================================
    // outputs
    assign bus_data_out = st.rdata;
    assign bus_data_oe = st.oe;
    assign dtack_n = !st.ack;
    assign first_timer_output = outs[0];
    assign second_timer_output = outs[1];
    assign third_timer_output = outs[2];
    assign fourth_timer_output = outs[3];
    assign timer_timeout = timeouts;

endmodule

// ===== dv/host_bus_model.sv
// host side of the strobe bus, one access per strobe
// assumes the bench calls xfer after reset, one access at a time
module host_bus_model
    import quad_timer_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              dtack_n,
    input  wire logic [DATA_W-1:0] bus_data_out,
    output logic                   chip_select_n,
    output logic                   bus_data_strobe_n,
    output logic                   bus_read_write,
    output logic      [ADDR_W-1:0] register_select,
    output logic      [DATA_W-1:0] bus_data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        chip_select_n = 1'b1;
        bus_data_strobe_n = 1'b1;
        bus_read_write = 1'b1;
        register_select = '0;
        bus_data_in = '0;
    end
    // ==========================================
    // access: all held until ack seen at a rising edge
    task automatic xfer(input logic rd, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q,
                        output logic ok);
        int n;
        @(negedge clk);
        chip_select_n = 1'b0;
        bus_data_strobe_n = 1'b0;
        bus_read_write = rd;
        register_select = a;
        bus_data_in = d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (dtack_n !== 1'b0 && n < 20);
        ok = (dtack_n === 1'b0);
        q = bus_data_out;
        @(negedge clk);
        chip_select_n = 1'b1;
        bus_data_strobe_n = 1'b1;
        // released data is not left looking valid
        bus_data_in = ~d;
        // strobe high across release and recover
        repeat (2) @(negedge clk);
    endtask
endmodule

// ===== dv/quad_timer_register_control_chk.sv
// checker on the quad timer pins: bus handshake and timeouts
// assumes one clock domain, nrst active low
module quad_timer_register_control_chk
    import quad_timer_pkg::*;
(
    input wire logic                  clk,
    input wire logic                  nrst,
    input wire logic                  chip_select_n,
    input wire logic                  bus_data_strobe_n,
    input wire logic                  bus_read_write,
    input wire logic [DATA_W-1:0]     bus_data_out,
    input wire logic                  bus_data_oe,
    input wire logic                  dtack_n,
    input wire logic                  third_timer_output,
    input wire logic                  fourth_timer_output,
    input wire logic [NUM_TIMERS-1:0] timer_timeout
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dck @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // ==========================================
    // bus handshake
    AST_ACK_CAUSE: assert property ($fell(dtack_n) |-> !$past(chip_select_n)
        && !$past(bus_data_strobe_n)) else $error("ack without access");
    AST_ACK_HOLD: assert property (!dtack_n && !chip_select_n
        && !bus_data_strobe_n |=> !dtack_n) else $error("ack dropped early");
    AST_ACK_RELEASE: assert property (!dtack_n && bus_data_strobe_n |=> dtack_n)
        else $error("ack not released");
    AST_RECOVER: assert property ($rose(dtack_n) |=> dtack_n)
        else $error("no recover cycle");
    AST_ACK_WITHIN: assert property (!chip_select_n && !bus_data_strobe_n
        |-> ##[0:3] !dtack_n) else $error("ack late");
    AST_OE_READ: assert property ($fell(dtack_n) |-> bus_data_oe == $past(bus_read_write))
        else $error("drive enable wrong");
    AST_DATA_STABLE: assert property (!bus_data_oe |-> $stable(bus_data_out))
        else $error("read data moved");
    // ==========================================
    // timeouts
    AST_PULSE_ONE: assert property (timer_timeout != '0
        |=> (timer_timeout & $past(timer_timeout)) == '0) else $error("pulse too long");
    AST_TOGGLE_C: assert property ($changed(third_timer_output) |-> timer_timeout[2])
        else $error("toggle without timeout");
    AST_TOGGLE_D: assert property (timer_timeout[3] |-> $changed(fourth_timer_output))
        else $error("timeout without toggle");
    cover property ($fell(dtack_n) && bus_data_oe);
    cover property (timer_timeout[0]);
    cover property (timer_timeout[3]);
endmodule

bind quad_timer_register_control quad_timer_register_control_chk chk (
    .clk(clk), .nrst(nrst), .chip_select_n(chip_select_n),
    .bus_data_strobe_n(bus_data_strobe_n), .bus_read_write(bus_read_write),
    .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe), .dtack_n(dtack_n),
    .third_timer_output(third_timer_output), .fourth_timer_output(fourth_timer_output),
    .timer_timeout(timer_timeout)
);

// ===== dv/testbench.sv
// self-checking bench for the quad timer block
// assumes host_bus_model and the bound checker are compiled alongside
module testbench
    import quad_timer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed { logic [4:0] a; logic [7:0] d; logic [7:0] e; } row_s;
    logic              clk;
    logic              nrst;
    logic              aux_a;
    logic              aux_b;
    logic              cs_n;
    logic              ds_n;
    logic              rw;
    logic [ADDR_W-1:0] rs;
    logic [DATA_W-1:0] din;
    logic [DATA_W-1:0] dout;
    logic              oe;
    logic              ack_n;
    logic [3:0]        tout;
    logic              out_a, out_b, out_c, out_d;
    int                error_cnt = 0;
    int                checks = 0;
    int                pulses [4];
    int                div [8] = '{1, 4, 10, 16, 50, 64, 100, 200};
    row_s              rows [11] = '{
        '{ADDR_A_CTRL, 8'hFF, 8'h1F}, '{ADDR_A_CTRL, 8'h00, 8'h00},
        '{ADDR_B_CTRL, 8'h9A, 8'h1A}, '{ADDR_B_CTRL, 8'h00, 8'h00},
        '{ADDR_CD_CTRL, 8'hFF, 8'h77}, '{ADDR_CD_CTRL, 8'h00, 8'h00},
        '{ADDR_A_DATA, 8'h3C, 8'h3C}, '{ADDR_B_DATA, 8'hA5, 8'hA5},
        '{ADDR_C_DATA, 8'h03, 8'h03}, '{ADDR_D_DATA, 8'h00, 8'h00},
        '{5'h1F, 8'h5A, 8'h00}};

    quad_timer_register_control uut (
        .clk(clk), .nrst(nrst), .chip_select_n(cs_n), .bus_data_strobe_n(ds_n),
        .bus_read_write(rw), .register_select(rs), .bus_data_in(din),
        .bus_data_out(dout), .bus_data_oe(oe), .dtack_n(ack_n),
        .first_timer_aux_input(aux_a), .second_timer_aux_input(aux_b),
        .first_timer_output(out_a), .second_timer_output(out_b),
        .third_timer_output(out_c), .fourth_timer_output(out_d), .timer_timeout(tout));
    host_bus_model host (
        .clk(clk), .dtack_n(ack_n), .bus_data_out(dout), .chip_select_n(cs_n),
        .bus_data_strobe_n(ds_n), .bus_read_write(rw), .register_select(rs),
        .bus_data_in(din));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        for (int i = 0; i < 4; i++) if (tout[i] === 1'b1) pulses[i]++;
    end
    // ==========================================
    // shared tasks
    task automatic complete_run();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] exp, got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic       ok;
        host.xfer(1'b0, a, d, q, ok);
        check("write ack", 16'h0001, 16'(ok));
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] q);
        logic ok;
        host.xfer(1'b1, a, 8'h00, q, ok);
        check("read ack", 16'h0001, 16'(ok));
    endtask
    task automatic gap(input int b, input int lim, output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (tout[b] !== 1'b1 && n < lim);
    endtask
    // first timeout after a mode change is not timed
    task automatic period(input int b, input int exp);
        int n;
        gap(b, 2000, n);
        gap(b, 2000, n);
        check("timeout gap", 16'(exp), 16'(n));
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        complete_run();
    end
    // ==========================================
    // main sequence
    initial begin
        logic [7:0] q;
        logic [7:0] q2;
        logic       o;
        int         n;
        nrst = 1'b0;
        aux_a = 1'b0;
        aux_b = 1'b0;
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        foreach (rows[i]) begin
            rd(rows[i].a, q);
            check("reset value", 16'h0000, 16'(q));
        end
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, q);
            check("register", 16'(rows[i].e), 16'(q));
        end
        wr(ADDR_A_DATA, 8'h02);
        for (int k = 1; k < 8; k++) begin
            wr(ADDR_A_CTRL, 8'(k));
            wr(ADDR_CD_CTRL, 8'(k << 4));
            period(0, div[k] * 2);
            period(2, div[k] * 3);
        end
        wr(ADDR_D_DATA, 8'h00);
        wr(ADDR_CD_CTRL, 8'h11);
        period(3, 1024);
        gap(2, 100, n);
        // right after a reload the count is far from 01
        wr(ADDR_C_DATA, 8'h05);
        gap(2, 100, n);
        check("old count kept", 16'h0001, 16'(n < 13));
        period(2, 20);
        wr(ADDR_CD_CTRL, 8'h01);
        rd(ADDR_C_DATA, q);
        repeat (50) @(negedge clk);
        rd(ADDR_C_DATA, q2);
        check("held count", 16'(q), 16'(q2));
        wr(ADDR_A_CTRL, 8'h10);
        wr(ADDR_A_DATA, 8'h01);
        wr(ADDR_A_CTRL, 8'h11);
        o = 1'b0;
        repeat (20) begin
            @(negedge clk);
            o |= out_a;
        end
        check("forced output", 16'h0000, 16'(o));
        wr(ADDR_A_CTRL, 8'h01);
        o = 1'b0;
        repeat (20) begin
            @(negedge clk);
            o |= out_a;
        end
        check("released output", 16'h0001, 16'(o));
        wr(ADDR_A_CTRL, 8'h09);
        pulses = '{0, 0, 0, 0};
        repeat (100) @(negedge clk);
        check("gated pulses", 16'h0000, 16'(pulses[0]));
        aux_a = 1'b1;
        period(0, 4);
        aux_a = 1'b0;
        wr(ADDR_A_CTRL, 8'h00);
        wr(ADDR_A_DATA, 8'h03);
        wr(ADDR_B_DATA, 8'h02);
        wr(ADDR_A_CTRL, 8'h08);
        wr(ADDR_B_CTRL, 8'h08);
        pulses = '{0, 0, 0, 0};
        repeat (6) begin
            aux_a = 1'b1;
            aux_b = 1'b1;
            repeat (4) @(negedge clk);
            aux_a = 1'b0;
            aux_b = 1'b0;
            repeat (4) @(negedge clk);
        end
        check("events a", 16'h0002, 16'(pulses[0]));
        check("events b", 16'h0003, 16'(pulses[1]));
        wr(ADDR_CD_CTRL, 8'h11);
        repeat (30) @(negedge clk);
        nrst = 1'b0;
        repeat (2) @(negedge clk);
        check("outputs in reset", 16'h0000, 16'({out_a, out_b, out_c, out_d, tout}));
        nrst = 1'b1;
        rd(ADDR_CD_CTRL, q);
        check("control after reset", 16'h0000, 16'(q));
        complete_run();
    end
endmodule
